// File: rtl/fdma_cfg.svh
// fdma_cfg.svh: offsets, field positions, codes and reset values of the dma channel
`ifndef FDMA_CFG_SVH
`define FDMA_CFG_SVH

// register byte offsets on the wishbone slave
`define FDMA_OFS_SRC     8'h00
`define FDMA_OFS_DST     8'h04
`define FDMA_OFS_TCOUNT  8'h08
`define FDMA_OFS_BSIZE   8'h0C
`define FDMA_OFS_BCOUNT  8'h10
`define FDMA_OFS_CTL     8'h14
`define FDMA_OFS_STAT    8'h18

// channel_control field positions
`define FDMA_CTL_W       13
`define FDMA_CTL_EN      0
`define FDMA_CTL_IRQEN   1
`define FDMA_CTL_BLOCK   2
`define FDMA_CTL_SRCM    3
`define FDMA_CTL_DSTM    5
`define FDMA_CTL_WORD    7
`define FDMA_CTL_BURST   8
`define FDMA_CTL_AREA    9
`define FDMA_CTL_SEL     10

// status field positions
`define FDMA_STA_DONE    0
`define FDMA_STA_ACTIVE  1

// address step modes
`define FDMA_STEP_FIX    2'h0
`define FDMA_STEP_INC    2'h1
`define FDMA_STEP_DEC    2'h2
`define FDMA_BYTE_STEP   24'h000001
`define FDMA_WORD_STEP   24'h000002

// request source select codes
`define FDMA_SEL_AUTO    3'h0
`define FDMA_SEL_EDGE    3'h1
`define FDMA_SEL_LEVEL   3'h2
`define FDMA_SEL_TMR0    3'h3
`define FDMA_SEL_TMR3    3'h6

// counter values and pin idle level
`define FDMA_ONE16       16'h0001
`define FDMA_ONE8        8'h01
`define FDMA_PIN_IDLE    1'b1

`endif

// File: rtl/fdma_pkg.sv
// fdma_pkg.sv: types shared by the dma channel files
package fdma_pkg;

    // transfer sequencer states
    typedef enum logic [2:0] {
        FDMA_IDLE,
        FDMA_BUSREQ,
        FDMA_READ,
        FDMA_WRITE,
        FDMA_RELEASE
    } fdma_state_type;

    // synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } fdma_sync_type;

endpackage

// File: rtl/fdma_req_sync.sv
// fdma_req_sync.sv: two-flop synchroniser and falling edge detect for the request pin
`timescale 1ns/10ps
`include "fdma_cfg.svh"
module fdma_req_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // pin and results
    input  wire logic pin_n,
    output logic      req_low,
    output logic      req_fall
);

    fdma_pkg::fdma_sync_type r_ff;
    fdma_pkg::fdma_sync_type nxt_r;

    // shift chain, first stage feeds only the second
    always_comb begin
        nxt_r    = r_ff;
        nxt_r.s1 = pin_n;
        nxt_r.s2 = r_ff.s1;
        nxt_r.s3 = r_ff.s2;
    end

    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_ff <= '{s1: `FDMA_PIN_IDLE, s2: `FDMA_PIN_IDLE, s3: `FDMA_PIN_IDLE};
        end else begin
            r_ff <= nxt_r;
        end
    end

    // level and edge from synchronised stages only
    assign req_low  = ~r_ff.s2;
    assign req_fall = r_ff.s3 & ~r_ff.s2;

endmodule

// File: rtl/fdma_channel.sv
// fdma_channel.sv: full-address dma channel with a classic wishbone register slave
//
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/10ps
`include "fdma_cfg.svh"
module fdma_channel (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // wishbone register slave
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [7:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_w,
    output logic      [31:0] wb_dat_r,
    output logic             wb_ack,
    // system bus arbitration
    output logic             bus_req,
    input  wire logic        bus_grant,
    input  wire logic        hp_req,
    // system bus master cycles
    output logic             mst_cyc,
    output logic             mst_we,
    output logic             mst_word,
    output logic      [23:0] mst_adr,
    output logic      [15:0] mst_dat_w,
    input  wire logic [15:0] mst_dat_r,
    input  wire logic        mst_ack,
    // external request and end pins
    input  wire logic        external_request_n,
    output logic             transfer_end_n,
    // timer requests and their forwarding
    input  wire logic        timer0_compare_a_irq,
    input  wire logic        timer1_compare_a_irq,
    input  wire logic        timer2_compare_a_irq,
    input  wire logic        timer3_compare_a_irq,
    output logic      [3:0]  timer_irq_to_cpu,
    output logic      [3:0]  timer_flag_clear,
    // completion interrupt
    output logic             completion_irq
);

    typedef struct packed {
        fdma_pkg::fdma_state_type st;
        logic [23:0]              src;
        logic [23:0]              dst;
        logic [23:0]              area_base;
        logic [15:0]              tcount;
        logic [15:0]              bcount;
        logic [7:0]               bsize;
        logic [7:0]               binit;
        logic [`FDMA_CTL_W-1:0]   ctl;
        logic                     done;
        logic                     pend;
        logic                     in_block;
        logic [31:0]              rdat;
        logic                     ack;
        logic                     breq;
        logic                     mcyc;
        logic                     mwe;
        logic                     mword;
        logic [23:0]              madr;
        logic [15:0]              mdat;
        logic                     endw_n;
        logic                     irq;
        logic [3:0]               fwd;
        logic [3:0]               fclr;
    } fdma_regs_type;

    fdma_regs_type r_ff;
    fdma_regs_type nxt_r;

    logic        req_low;
    logic        req_fall;
    logic [3:0]  tmr;
    logic [31:0] rd_word;
    logic [2:0]  sel;
    logic [1:0]  tidx;
    logic        is_tmr;
    logic        en;
    logic        blk;

    // request pin crossing into the clock domain
    fdma_req_sync u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .pin_n    (external_request_n),
        .req_low  (req_low),
        .req_fall (req_fall)
    );

    // decoded control fields
    assign tmr    = {timer3_compare_a_irq, timer2_compare_a_irq,
                     timer1_compare_a_irq, timer0_compare_a_irq};
    assign sel    = r_ff.ctl[`FDMA_CTL_SEL+2:`FDMA_CTL_SEL];
    assign is_tmr = (sel >= `FDMA_SEL_TMR0) && (sel <= `FDMA_SEL_TMR3);
    assign tidx   = 2'(sel - `FDMA_SEL_TMR0);
    assign en     = r_ff.ctl[`FDMA_CTL_EN];
    assign blk    = r_ff.ctl[`FDMA_CTL_BLOCK];

    // byte-lane merge of a wishbone write
    function automatic logic [31:0] mrg(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction

    // address step by unit size and mode
    function automatic logic [23:0] step(input logic [23:0] a, input logic [1:0] m,
                                         input logic w);
        logic [23:0] inc;
        inc = w ? `FDMA_WORD_STEP : `FDMA_BYTE_STEP;
        unique case (m)
            `FDMA_STEP_INC: return a + inc;
            `FDMA_STEP_DEC: return a - inc;
            default:        return a;
        endcase
    endfunction

    // register read mux
    always_comb begin
        rd_word = '0;
        case (wb_adr)
            `FDMA_OFS_SRC:    rd_word = 32'(r_ff.src);
            `FDMA_OFS_DST:    rd_word = 32'(r_ff.dst);
            `FDMA_OFS_TCOUNT: rd_word = 32'(r_ff.tcount);
            `FDMA_OFS_BSIZE:  rd_word = 32'({r_ff.bsize, r_ff.binit});
            `FDMA_OFS_BCOUNT: rd_word = 32'(r_ff.bcount);
            `FDMA_OFS_CTL:    rd_word = 32'(r_ff.ctl);
            `FDMA_OFS_STAT: begin
                rd_word[`FDMA_STA_DONE]   = r_ff.done;
                rd_word[`FDMA_STA_ACTIVE] = (r_ff.st != fdma_pkg::FDMA_IDLE) | r_ff.in_block;
            end
            default:          rd_word = '0;
        endcase
    end

    // slave, request capture and transfer sequencer
    always_comb begin
        logic        trig;
        logic        fin;
        logic        keep;
        logic        last;
        logic [31:0] wimg;
        trig  = 1'b0;
        fin   = 1'b0;
        keep  = 1'b0;
        last  = 1'b0;
        wimg  = '0;
        nxt_r = r_ff;
        nxt_r.ack  = 1'b0;
        nxt_r.fclr = '0;
        // wishbone access, answered one cycle later
        if (wb_cyc && wb_stb && !r_ff.ack) begin
            nxt_r.ack  = 1'b1;
            nxt_r.rdat = rd_word;
            wimg       = mrg(rd_word, wb_dat_w, wb_sel);
            if (wb_we) begin
                case (wb_adr)
                    `FDMA_OFS_SRC:    nxt_r.src    = 24'(wimg);
                    `FDMA_OFS_DST:    nxt_r.dst    = 24'(wimg);
                    `FDMA_OFS_TCOUNT: nxt_r.tcount = 16'(wimg);
                    `FDMA_OFS_BSIZE:  {nxt_r.bsize, nxt_r.binit} = 16'(wimg);
                    `FDMA_OFS_BCOUNT: nxt_r.bcount = 16'(wimg);
                    `FDMA_OFS_CTL:    nxt_r.ctl    = `FDMA_CTL_W'(wimg);
                    `FDMA_OFS_STAT:   nxt_r.done   = r_ff.done & ~wb_dat_w[`FDMA_STA_DONE];
                    default:          nxt_r.ctl    = nxt_r.ctl;
                endcase
            end
        end
        // falling edges wait until taken; dropped while disabled
        nxt_r.pend = req_fall | (r_ff.pend & en);
        // triggers allowed per mode
        if (blk) begin
            trig = ((sel == `FDMA_SEL_EDGE) && r_ff.pend) || (is_tmr && tmr[tidx]);
        end else begin
            trig = (sel == `FDMA_SEL_AUTO)
                || ((sel == `FDMA_SEL_EDGE) && r_ff.pend)
                || ((sel == `FDMA_SEL_LEVEL) && req_low);
        end
        last = blk ? (r_ff.bsize == `FDMA_ONE8) : (r_ff.tcount == `FDMA_ONE16);
        unique case (r_ff.st)
            fdma_pkg::FDMA_IDLE: begin
                if (en && (trig || r_ff.in_block)) begin
                    nxt_r.st   = fdma_pkg::FDMA_BUSREQ;
                    nxt_r.breq = 1'b1;
                    if (!r_ff.in_block) begin
                        if (sel == `FDMA_SEL_EDGE) begin
                            nxt_r.pend = req_fall;
                        end
                        if (is_tmr) begin
                            nxt_r.fclr[tidx] = 1'b1;
                        end
                        if (blk) begin
                            nxt_r.in_block  = 1'b1;
                            nxt_r.area_base = r_ff.ctl[`FDMA_CTL_AREA] ? r_ff.src
                                                                       : r_ff.dst;
                        end
                    end
                end
            end
            fdma_pkg::FDMA_BUSREQ: begin
                if (bus_grant) begin
                    nxt_r.st    = fdma_pkg::FDMA_READ;
                    nxt_r.mcyc  = 1'b1;
                    nxt_r.mwe   = 1'b0;
                    nxt_r.mword = r_ff.ctl[`FDMA_CTL_WORD];
                    nxt_r.madr  = r_ff.src;
                end
            end
            fdma_pkg::FDMA_READ: begin
                // read data is written straight back out
                if (mst_ack) begin
                    nxt_r.st     = fdma_pkg::FDMA_WRITE;
                    nxt_r.mwe    = 1'b1;
                    nxt_r.madr   = r_ff.dst;
                    nxt_r.mdat   = mst_dat_r;
                    nxt_r.endw_n = ~last;
                end
            end
            fdma_pkg::FDMA_WRITE: begin
                if (mst_ack) begin
                    nxt_r.mcyc   = 1'b0;
                    nxt_r.mwe    = 1'b0;
                    nxt_r.endw_n = 1'b1;
                    nxt_r.src = step(r_ff.src, r_ff.ctl[`FDMA_CTL_SRCM+1:`FDMA_CTL_SRCM],
                                     r_ff.ctl[`FDMA_CTL_WORD]);
                    nxt_r.dst = step(r_ff.dst, r_ff.ctl[`FDMA_CTL_DSTM+1:`FDMA_CTL_DSTM],
                                     r_ff.ctl[`FDMA_CTL_WORD]);
                    if (blk) begin
                        nxt_r.bsize = r_ff.bsize - `FDMA_ONE8;
                        if (last) begin
                            nxt_r.bsize    = r_ff.binit;
                            nxt_r.bcount   = r_ff.bcount - `FDMA_ONE16;
                            nxt_r.in_block = 1'b0;
                            if (r_ff.ctl[`FDMA_CTL_AREA]) begin
                                nxt_r.src = r_ff.area_base;
                            end else begin
                                nxt_r.dst = r_ff.area_base;
                            end
                            fin = (r_ff.bcount == `FDMA_ONE16);
                        end
                        keep = !last && !hp_req;
                    end else begin
                        // zero load wraps, giving the full 65,536 count
                        nxt_r.tcount = r_ff.tcount - `FDMA_ONE16;
                        fin  = last;
                        keep = !last && (sel == `FDMA_SEL_AUTO)
                            && r_ff.ctl[`FDMA_CTL_BURST] && !hp_req;
                    end
                    if (fin) begin
                        nxt_r.ctl[`FDMA_CTL_EN] = 1'b0;
                        nxt_r.done = 1'b1;
                    end
                    if (keep) begin
                        nxt_r.st    = fdma_pkg::FDMA_READ;
                        nxt_r.mcyc  = 1'b1;
                        nxt_r.madr  = nxt_r.src;
                    end else begin
                        nxt_r.st   = fdma_pkg::FDMA_RELEASE;
                        nxt_r.breq = 1'b0;
                    end
                end
            end
            fdma_pkg::FDMA_RELEASE: begin
                nxt_r.st = fdma_pkg::FDMA_IDLE;
            end
        endcase
        // completion interrupt gated by its enable
        nxt_r.irq = nxt_r.done & nxt_r.ctl[`FDMA_CTL_IRQEN];
        // selected timer request is kept from the processor
        for (int i = 0; i < 4; i++) begin
            nxt_r.fwd[i] = tmr[i] & ~(nxt_r.ctl[`FDMA_CTL_EN] && is_tmr && tidx == 2'(i));
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_ff        <= '0;
            r_ff.endw_n <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // outputs straight from flip-flops
    assign wb_dat_r         = r_ff.rdat;
    assign wb_ack           = r_ff.ack;
    assign bus_req          = r_ff.breq;
    assign mst_cyc          = r_ff.mcyc;
    assign mst_we           = r_ff.mwe;
    assign mst_word         = r_ff.mword;
    assign mst_adr          = r_ff.madr;
    assign mst_dat_w        = r_ff.mdat;
    assign transfer_end_n   = r_ff.endw_n;
    assign timer_irq_to_cpu = r_ff.fwd;
    assign timer_flag_clear = r_ff.fclr;
    assign completion_irq   = r_ff.irq;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic wr_done;
    assign wr_done = (r_ff.st == fdma_pkg::FDMA_WRITE) && mst_ack;

    property p_count_end;
        wr_done && !blk && (r_ff.tcount == `FDMA_ONE16)
            |=> !r_ff.ctl[`FDMA_CTL_EN] && (r_ff.st == fdma_pkg::FDMA_RELEASE);
    endproperty
    a_count_end: assert property (p_count_end) else $error("count end did not stop");

    property p_irq_end;
        wr_done && !blk && (r_ff.tcount == `FDMA_ONE16) && r_ff.ctl[`FDMA_CTL_IRQEN]
            |=> completion_irq;
    endproperty
    a_irq_end: assert property (p_irq_end) else $error("no completion interrupt");

    property p_steal;
        wr_done && !blk && !r_ff.ctl[`FDMA_CTL_BURST]
            |=> !bus_req ##1 (r_ff.st == fdma_pkg::FDMA_IDLE);
    endproperty
    a_steal: assert property (p_steal) else $error("bus not handed back");

    property p_burst;
        wr_done && !blk && r_ff.ctl[`FDMA_CTL_BURST] && (sel == `FDMA_SEL_AUTO)
            && (r_ff.tcount != `FDMA_ONE16) && !hp_req
            |=> bus_req && mst_cyc && !mst_we && (mst_adr == r_ff.src);
    endproperty
    a_burst: assert property (p_burst) else $error("burst dropped bus");

    property p_reload;
        wr_done && blk && (r_ff.bsize == `FDMA_ONE8) |=> r_ff.bsize == $past(r_ff.binit);
    endproperty
    a_reload: assert property (p_reload) else $error("block size not reloaded");

    property p_area;
        wr_done && blk && (r_ff.bsize == `FDMA_ONE8) && !r_ff.ctl[`FDMA_CTL_AREA]
            |=> r_ff.dst == $past(r_ff.area_base);
    endproperty
    a_area: assert property (p_area) else $error("block area not restored");

    property p_end_low;
        (r_ff.st == fdma_pkg::FDMA_WRITE) && blk && (r_ff.bsize == `FDMA_ONE8)
            |-> !transfer_end_n;
    endproperty
    a_end_low: assert property (p_end_low) else $error("transfer end not low");

    property p_block_src;
        (r_ff.st == fdma_pkg::FDMA_IDLE) && !r_ff.in_block && blk
            && ((sel == `FDMA_SEL_AUTO) || (sel == `FDMA_SEL_LEVEL))
            |=> (r_ff.st == fdma_pkg::FDMA_IDLE)[*2];
    endproperty
    a_block_src: assert property (p_block_src) else $error("block mode took bad trigger");

    property p_step;
        wr_done && !blk && r_ff.ctl[`FDMA_CTL_WORD]
            && (r_ff.ctl[`FDMA_CTL_SRCM+1:`FDMA_CTL_SRCM] == `FDMA_STEP_INC)
            |=> r_ff.src == $past(r_ff.src) + `FDMA_WORD_STEP;
    endproperty
    a_step: assert property (p_step) else $error("word step wrong");

endmodule

// File: test/fdma_mem.sv
// fdma_mem.sv: system bus arbiter and memory model for the dma channel
`timescale 1ns/10ps
module fdma_mem (
    // clock
    input  wire logic        clk,
    // arbitration
    input  wire logic        bus_req,
    output logic             bus_grant,
    // master cycles
    input  wire logic        mst_cyc,
    input  wire logic        mst_we,
    input  wire logic [23:0] mst_adr,
    input  wire logic [15:0] mst_dat_w,
    output logic      [15:0] mst_dat_r,
    output logic             mst_ack,
    // wait states per cycle
    input  wire logic [1:0]  ws
);
    logic [15:0] mem [0:255];
    logic [1:0]  cnt = 2'h0;
    initial bus_grant = 1'b0;
    initial mst_ack = 1'b0;
    initial mst_dat_r = 16'h0000;
    // grant one cycle late; ack after ws waits; idle data toggles
    always @(posedge clk) begin
        bus_grant <= bus_req;
        mst_ack <= 1'b0;
        mst_dat_r <= ~mst_dat_r;
        if (mst_cyc && !mst_ack) begin
            cnt <= cnt + 2'h1;
            if (cnt == ws) begin
                cnt <= 2'h0;
                mst_ack <= 1'b1;
                if (mst_we) mem[mst_adr[7:0]] <= mst_dat_w;
                else mst_dat_r <= mem[mst_adr[7:0]];
            end
        end
    end
endmodule

// File: test/tb_fdma_channel.sv
// tb_fdma_channel.sv: register driven tests of the dma channel
`timescale 1ns/10ps
`include "fdma_cfg.svh"
module tb_fdma_channel;
    logic        clk = 0, sys_rst = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'hF;
    logic [31:0] wb_dat_w = 32'h0, wb_dat_r, q;
    logic        wb_ack, bus_req, bus_grant, mst_cyc, mst_we, mst_word, mst_ack;
    logic [23:0] mst_adr;
    logic [15:0] mst_dat_w, mst_dat_r;
    logic        pin_n = 1, t0 = 0, t1 = 0, transfer_end_n, completion_irq, req_q = 0;
    logic [3:0]  timer_irq_to_cpu, timer_flag_clear;
    logic [1:0]  ws = 2'h0;
    logic        hp_req = 0;
    int          n_errors = 0, checks = 0, nreq = 0, nend = 0, nclr = 0, n;
    always #5 clk = ~clk;
    fdma_channel fdma_channel_i (.clk, .sys_rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel,
        .wb_dat_w, .wb_dat_r, .wb_ack, .bus_req, .bus_grant, .hp_req, .mst_cyc,
        .mst_we, .mst_word, .mst_adr, .mst_dat_w, .mst_dat_r, .mst_ack,
        .external_request_n(pin_n), .transfer_end_n, .timer0_compare_a_irq(t0),
        .timer1_compare_a_irq(t1), .timer2_compare_a_irq(1'b0),
        .timer3_compare_a_irq(1'b0), .timer_irq_to_cpu, .timer_flag_clear, .completion_irq);
    fdma_mem fdma_mem_i (.clk, .bus_req, .bus_grant, .mst_cyc, .mst_we, .mst_adr,
        .mst_dat_w, .mst_dat_r, .mst_ack, .ws);
    // memory pattern from address
    function automatic logic [15:0] pat(input logic [7:0] a);
        return {a ^ 8'h5A, a};
    endfunction
    // counts request rises, ending writes, timer flag clears
    always @(posedge clk) begin
        req_q <= bus_req;
        if (bus_req && !req_q) nreq++;
        if (!transfer_end_n && mst_we && mst_ack) nend++;
        if (timer_flag_clear[0]) nclr++;
        if (timer_flag_clear[0]) t0 <= 1'b0;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one classic wishbone cycle, read data left in q
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_w <= d;
        @(posedge clk);
        while (wb_ack !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        if (k == 20) n_errors++;
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask
    // poll until hardware clears the enable bit
    task automatic wait_off();
        q = 32'h1;
        for (n = 0; n < 300 && q[0] !== 1'b0; n++) wb(1'b0, `FDMA_OFS_CTL, 32'h0);
        if (n == 300) n_errors++;
    endtask
    // falling edge on the pin, then wait out one bus tenure
    task automatic pulse();
        pin_n <= 1'b0;
        repeat (4) @(posedge clk);
        pin_n <= 1'b1;
        for (n = 0; n < 30 && bus_req !== 1'b1; n++) @(posedge clk);
        for (n = 0; n < 200 && bus_req !== 1'b0; n++) @(posedge clk);
    endtask
    task automatic cfg(input logic [31:0] s, input logic [31:0] d, input logic [31:0] c);
        wb(1'b1, `FDMA_OFS_SRC, s);
        wb(1'b1, `FDMA_OFS_DST, d);
        wb(1'b1, `FDMA_OFS_TCOUNT, c);
        wb(1'b1, `FDMA_OFS_STAT, 32'h1);
        nreq = 0;
        nend = 0;
    endtask
    task automatic print_verdict();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #300000;
        n_errors++;
        print_verdict();
    end
    initial begin
        for (int i = 0; i < 256; i++) fdma_mem_i.mem[i] = pat(i[7:0]);
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk(transfer_end_n, 1'b1);
        // reset values and an unmapped place
        wb(1'b1, 8'h1C, 32'hFFFFFFFF);
        for (int a = 0; a <= 8'h1C; a += 4) begin
            wb(1'b0, a[7:0], 32'h0);
            chk(q, 32'h0);
        end
        // normal auto cycle steal, word, both increment
        cfg(32'h10, 32'h40, 32'h3);
        wb(1'b1, `FDMA_OFS_CTL, 32'h0AB);
        wait_off();
        chk(nreq, 3);
        chk(nend, 1);
        for (int i = 0; i < 6; i += 2) chk(fdma_mem_i.mem[8'h40 + i], pat(8'h10 + i));
        wb(1'b0, `FDMA_OFS_SRC, 32'h0);
        chk(q, 32'h16);
        wb(1'b0, `FDMA_OFS_DST, 32'h0);
        chk(q, 32'h46);
        wb(1'b0, `FDMA_OFS_TCOUNT, 32'h0);
        chk(q, 32'h0);
        chk(completion_irq, 1'b1);
        chk(mst_word, 1'b1);
        // normal auto burst, byte, destination decrements, no interrupt
        ws <= 2'h2;
        cfg(32'h20, 32'h60, 32'h2);
        wb(1'b1, `FDMA_OFS_CTL, 32'h149);
        wait_off();
        chk(nreq, 1);
        chk(completion_irq, 1'b0);
        wb(1'b0, `FDMA_OFS_SRC, 32'h0);
        chk(q, 32'h22);
        wb(1'b0, `FDMA_OFS_DST, 32'h0);
        chk(q, 32'h5E);
        // burst gives way to a higher master after every unit
        hp_req <= 1'b1;
        cfg(32'h20, 32'h60, 32'h2);
        wb(1'b1, `FDMA_OFS_CTL, 32'h149);
        wait_off();
        chk(nreq, 2);
        chk(mst_word, 1'b0);
        hp_req <= 1'b0;
        // block mode, pin edge, two blocks of two words
        ws <= 2'h0;
        cfg(32'h30, 32'h70, 32'h0);
        wb(1'b1, `FDMA_OFS_BSIZE, 32'h0202);
        wb(1'b1, `FDMA_OFS_BCOUNT, 32'h2);
        wb(1'b1, `FDMA_OFS_CTL, 32'h4AF);
        pulse();
        wb(1'b0, `FDMA_OFS_BCOUNT, 32'h0);
        chk(q, 32'h1);
        wb(1'b0, `FDMA_OFS_CTL, 32'h0);
        chk(q[0], 1'b1);
        pulse();
        wait_off();
        chk(nreq, 2);
        chk(nend, 2);
        chk(fdma_mem_i.mem[8'h72], pat(8'h36));
        wb(1'b0, `FDMA_OFS_SRC, 32'h0);
        chk(q, 32'h38);
        wb(1'b0, `FDMA_OFS_DST, 32'h0);
        chk(q, 32'h70);
        wb(1'b0, `FDMA_OFS_BSIZE, 32'h0);
        chk(q, 32'h0202);
        chk(completion_irq, 1'b1);
        // block with auto, normal with timer: both refused
        t0 <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            cfg(32'h80, 32'h90, 32'h1);
            wb(1'b1, `FDMA_OFS_CTL, i ? 32'hC01 : 32'h0AD);
            repeat (30) @(posedge clk);
            chk(nreq, 0);
            wb(1'b1, `FDMA_OFS_CTL, 32'h0);
        end
        // block started by timer 0, timer 1 still forwarded
        t0 <= 1'b0;
        t1 <= 1'b1;
        wb(1'b1, `FDMA_OFS_BSIZE, 32'h0101);
        wb(1'b1, `FDMA_OFS_BCOUNT, 32'h1);
        wb(1'b1, `FDMA_OFS_CTL, 32'hEAD);
        nclr = 0;
        t0 <= 1'b1;
        repeat (2) @(posedge clk);
        chk(timer_irq_to_cpu[1:0], 2'h2);
        wait_off();
        chk(nclr, 1);
        chk(fdma_mem_i.mem[8'h90], pat(8'h80));
        wb(1'b0, `FDMA_OFS_SRC, 32'h0);
        chk(q, 32'h80);
        wb(1'b0, `FDMA_OFS_DST, 32'h0);
        chk(q, 32'h92);
        t1 <= 1'b0;
        // count zero, one edge: counter wraps, channel stays on
        cfg(32'hA0, 32'hA1, 32'h0);
        wb(1'b1, `FDMA_OFS_CTL, 32'h401);
        pulse();
        chk(nreq, 1);
        wb(1'b0, `FDMA_OFS_TCOUNT, 32'h0);
        chk(q, 32'hFFFF);
        wb(1'b0, `FDMA_OFS_CTL, 32'h0);
        chk(q[0], 1'b1);
        wb(1'b1, `FDMA_OFS_CTL, 32'h0);
        // level held low runs the count, releasing between units
        cfg(32'hA0, 32'hA1, 32'h3);
        pin_n <= 1'b0;
        wb(1'b1, `FDMA_OFS_CTL, 32'h801);
        wait_off();
        chk(nreq, 3);
        pin_n <= 1'b1;
        print_verdict();
    end
endmodule
